// ==== pmm_power_manager.sv ====
// power mode manager of a five-port switch: mode register, go-sleep timer,
// per-port phy power down and the hardware power-down pin.
// assumes chip_powerdown_n_pin and cable_energy_pin are asynchronous; the
// register port, autoneg_en and miim_pd come from sys_clk logic.
`timescale 1ns/1ps
module pmm_power_manager #(
    parameter int unsigned ED_PULSE_PERIOD_CYC = pmm_pkg::ED_PULSE_PERIOD_CYC,
    parameter int unsigned SLEEP_UNIT_CYC = pmm_pkg::SLEEP_UNIT_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic chip_powerdown_n_pin,
    input wire logic [4:0] cable_energy_pin,
    input wire logic [4:0] autoneg_en,
    input wire logic [4:0] miim_pd,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_ack,
    output logic pll_clk_en,
    output logic mac_en,
    output logic host_if_en,
    output logic [4:0] phy_tx_en,
    output logic [4:0] phy_rx_en,
    output logic energy_pulse,
    output logic low_power_state,
    output logic internal_reset
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic pd_s1;
    logic pd_s2;
    logic [4:0] en_s1;
    logic [4:0] en_s2;

    // pin sync resets to released so a reset does not fake a power-down
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pd_s1 <= 1'b1;
            pd_s2 <= 1'b1;
            en_s1 <= 5'h00;
            en_s2 <= 5'h00;
        end else begin
            pd_s1 <= chip_powerdown_n_pin;
            pd_s2 <= pd_s1;
            en_s1 <= cable_energy_pin;
            en_s2 <= en_s1;
        end
    end

    logic pin_low;
    logic energy_any;
    logic ed_mode;
    logic pulse_raw;
    logic sleep_tick;
    pmm_pkg::pmm_state_t state;

    assign pin_low = ~pd_s2;
    assign energy_any = |en_s2;
    assign ed_mode = (state == pmm_pkg::ST_ED_AWAKE) || (state == pmm_pkg::ST_ED_SLEEP);

    // ------------------------------------------------------------
    // timers
    // ------------------------------------------------------------
    // beacon runs only while detect mode sees no link partner
    pmm_pulse_gen #(
        .PERIOD(ED_PULSE_PERIOD_CYC),
        .WIDTH(pmm_pkg::ED_PULSE_WIDTH_CYC)
    ) u_beacon (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .run(ed_mode && !energy_any),
        .tick(),
        .pulse(pulse_raw)
    );

    // go-sleep time base; its phase restarts on every energy burst
    pmm_pulse_gen #(
        .PERIOD(SLEEP_UNIT_CYC),
        .WIDTH(1)
    ) u_sleep_unit (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .run((state == pmm_pkg::ST_ED_AWAKE) && !energy_any),
        .tick(sleep_tick),
        .pulse()
    );

    // ------------------------------------------------------------
    // state, registers and outputs
    // ------------------------------------------------------------
    logic [1:0] mode;
    logic [7:0] go_sleep;
    logic [7:0] port_ctrl [pmm_pkg::NUM_PORTS];
    logic [7:0] sleep_cnt;
    pmm_pkg::pmm_state_t next_state;
    logic [1:0] next_mode;
    logic [7:0] next_go_sleep;
    logic [7:0] next_port_ctrl [pmm_pkg::NUM_PORTS];
    logic [7:0] next_sleep_cnt;
    logic [7:0] next_reg_rdata;
    logic next_reg_ack;
    logic next_pll_clk_en;
    logic next_mac_en;
    logic next_host_if_en;
    logic [4:0] next_phy_tx_en;
    logic [4:0] next_phy_rx_en;
    logic next_energy_pulse;
    logic next_low_power_state;
    logic next_internal_reset;
    logic host_ok;
    logic awake;
    logic [4:0] port_pd;
    logic [4:0] psave_port;

    // host is served in run and in the awake half of detect mode
    assign host_ok = (state == pmm_pkg::ST_RUN) || (state == pmm_pkg::ST_ED_AWAKE);
    assign awake = host_ok;

    always_comb begin
        next_state = state;
        next_mode = mode;
        next_go_sleep = go_sleep;
        next_port_ctrl = port_ctrl;
        next_sleep_cnt = sleep_cnt;
        next_reg_rdata = reg_rdata;
        next_reg_ack = 1'b0;
        next_internal_reset = 1'b0;
        case (state)
            pmm_pkg::ST_HW_PD: begin
                if (!pin_low) begin
                    next_state = pmm_pkg::ST_RUN;
                    next_internal_reset = 1'b1;
                end
            end
            pmm_pkg::ST_RUN: begin
                // saving mode stays in run; only the phy receiver enables differ
                case (mode)
                    pmm_pkg::MODE_ENERGY: begin
                        next_state = pmm_pkg::ST_ED_AWAKE;
                        next_sleep_cnt = 8'h00;
                    end
                    pmm_pkg::MODE_SOFT_PD: next_state = pmm_pkg::ST_SOFT_PD;
                    default: next_state = pmm_pkg::ST_RUN;
                endcase
            end
            pmm_pkg::ST_ED_AWAKE: begin
                if (energy_any) begin
                    next_sleep_cnt = 8'h00;
                end else if (sleep_tick) begin
                    // strictly longer than the programmed time
                    if (sleep_cnt >= go_sleep) begin
                        next_state = pmm_pkg::ST_ED_SLEEP;
                    end else begin
                        next_sleep_cnt = sleep_cnt + 8'h01;
                    end
                end
            end
            pmm_pkg::ST_ED_SLEEP: begin
                if (energy_any) begin
                    next_state = pmm_pkg::ST_ED_AWAKE;
                    next_sleep_cnt = 8'h00;
                end
            end
            pmm_pkg::ST_SOFT_PD: begin
                // the access itself is a dummy: it only wakes the chip
                if (reg_wr || reg_rd) begin
                    next_state = pmm_pkg::ST_RUN;
                    next_internal_reset = 1'b1;
                end
            end
            default: next_state = pmm_pkg::ST_RUN;
        endcase
        // register access while the host interface is enabled
        if (host_ok && (reg_wr || reg_rd)) begin
            next_reg_ack = 1'b1;
            next_reg_rdata = 8'h00;
            if (reg_addr == pmm_pkg::MODE_CTRL_OFS) begin
                next_reg_rdata[pmm_pkg::MODE_POS +: 2] = mode;
                if (reg_wr && state == pmm_pkg::ST_RUN) begin
                    next_mode = reg_wdata[pmm_pkg::MODE_POS +: 2];
                end
            end
            if (reg_addr == pmm_pkg::SLEEP_OFS) begin
                next_reg_rdata = go_sleep;
                if (reg_wr) begin
                    next_go_sleep = reg_wdata;
                end
            end
            for (int i = 0; i < pmm_pkg::NUM_PORTS; i++) begin
                if (reg_addr == 8'(pmm_pkg::PORT_CTRL_OFS + pmm_pkg::PORT_STRIDE * i)) begin
                    next_reg_rdata = port_ctrl[i];
                    if (reg_wr) begin
                        next_port_ctrl[i] = reg_wdata;
                    end
                end
            end
        end
        // internal reset returns every register to its default
        if (next_internal_reset) begin
            next_mode = pmm_pkg::MODE_RST;
            next_go_sleep = pmm_pkg::SLEEP_RST;
            for (int i = 0; i < pmm_pkg::NUM_PORTS; i++) begin
                next_port_ctrl[i] = pmm_pkg::PORT_CTRL_RST;
            end
            next_sleep_cnt = 8'h00;
        end
        // the pin overrides every mode
        if (pin_low) begin
            next_state = pmm_pkg::ST_HW_PD;
            next_internal_reset = 1'b0;
            next_reg_ack = 1'b0;
        end
    end

    // block enables follow the current state; one cycle behind it
    always_comb begin
        for (int i = 0; i < pmm_pkg::NUM_PORTS; i++) begin
            port_pd[i] = port_ctrl[i][pmm_pkg::PORT_PD_BIT] | miim_pd[i];
            psave_port[i] = (mode == pmm_pkg::MODE_PSAVE) && autoneg_en[i] && !en_s2[i];
        end
        next_pll_clk_en = awake;
        next_mac_en = awake;
        next_host_if_en = awake;
        next_phy_tx_en = awake ? ~port_pd : 5'h00;
        // receiver comes back as soon as the line shows energy
        next_phy_rx_en = awake ? (~port_pd & ~psave_port) : 5'h00;
        next_energy_pulse = pulse_raw && ed_mode && !energy_any;
        next_low_power_state = (state == pmm_pkg::ST_ED_SLEEP);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state <= pmm_pkg::ST_RUN;
            mode <= pmm_pkg::MODE_RST;
            go_sleep <= pmm_pkg::SLEEP_RST;
            for (int i = 0; i < pmm_pkg::NUM_PORTS; i++) begin
                port_ctrl[i] <= pmm_pkg::PORT_CTRL_RST;
            end
            sleep_cnt <= 8'h00;
            reg_rdata <= 8'h00;
            reg_ack <= 1'b0;
            internal_reset <= 1'b0;
            pll_clk_en <= 1'b0;
            mac_en <= 1'b0;
            host_if_en <= 1'b0;
            phy_tx_en <= 5'h00;
            phy_rx_en <= 5'h00;
            energy_pulse <= 1'b0;
            low_power_state <= 1'b0;
        end else begin
            state <= next_state;
            mode <= next_mode;
            go_sleep <= next_go_sleep;
            port_ctrl <= next_port_ctrl;
            sleep_cnt <= next_sleep_cnt;
            reg_rdata <= next_reg_rdata;
            reg_ack <= next_reg_ack;
            internal_reset <= next_internal_reset;
            pll_clk_en <= next_pll_clk_en;
            mac_en <= next_mac_en;
            host_if_en <= next_host_if_en;
            phy_tx_en <= next_phy_tx_en;
            phy_rx_en <= next_phy_rx_en;
            energy_pulse <= next_energy_pulse;
            low_power_state <= next_low_power_state;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    property p_hw_pd;
        pin_low |-> ##2 (!pll_clk_en && !mac_en && !host_if_en && phy_tx_en == 5'h00);
    endproperty
    a_hw_pd: assert property (p_hw_pd) else $error("power-down pin did not power off");

    property p_hw_release;
        (state == pmm_pkg::ST_HW_PD) && !pin_low |=> internal_reset && mode == 2'h0;
    endproperty
    a_hw_release: assert property (p_hw_release) else $error("no reset on pin release");

    property p_normal;
        (state == pmm_pkg::ST_RUN) && (mode == 2'h0) |=> pll_clk_en && mac_en && host_if_en;
    endproperty
    a_normal: assert property (p_normal) else $error("normal mode not fully on");

    property p_mode_lock;
        ed_mode |=> $stable(mode);
    endproperty
    a_mode_lock: assert property (p_mode_lock) else $error("mode changed in detect mode");

    property p_enter_ed;
        (state == pmm_pkg::ST_RUN) && (mode == 2'h1) && !pin_low |=> state == pmm_pkg::ST_ED_AWAKE;
    endproperty
    a_enter_ed: assert property (p_enter_ed) else $error("detect mode not entered");

    property p_sleep_off;
        (state == pmm_pkg::ST_ED_SLEEP) |=> !pll_clk_en && phy_tx_en == 5'h00 && low_power_state;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("low power left logic on");

    property p_wake;
        (state == pmm_pkg::ST_ED_SLEEP) && energy_any && !pin_low |=> state == pmm_pkg::ST_ED_AWAKE
            ##1 pll_clk_en;
    endproperty
    a_wake: assert property (p_wake) else $error("energy did not wake");

    property p_soft_pd;
        (state == pmm_pkg::ST_SOFT_PD) |=> !pll_clk_en && !mac_en && phy_rx_en == 5'h00;
    endproperty
    a_soft_pd: assert property (p_soft_pd) else $error("soft power down left logic on");

    property p_soft_wake;
        (state == pmm_pkg::ST_SOFT_PD) && (reg_wr || reg_rd) && !pin_low
            |=> state == pmm_pkg::ST_RUN && internal_reset && !reg_ack;
    endproperty
    a_soft_wake: assert property (p_soft_wake) else $error("host access did not wake");

    property p_psave_rx;
        (state == pmm_pkg::ST_RUN) && psave_port[0] |=> !phy_rx_en[0] && pll_clk_en && mac_en;
    endproperty
    a_psave_rx: assert property (p_psave_rx) else $error("saving mode receiver wrong");

    property p_port_pd;
        (state == pmm_pkg::ST_RUN) && port_ctrl[0][3] |=> !phy_tx_en[0] && !phy_rx_en[0];
    endproperty
    a_port_pd: assert property (p_port_pd) else $error("port power-down ignored");

    c_sleep: cover property ((state == pmm_pkg::ST_ED_AWAKE) ##1 (state == pmm_pkg::ST_ED_SLEEP));
    c_soft_wake: cover property ((state == pmm_pkg::ST_SOFT_PD) ##1 internal_reset);
    c_psave: cover property ((mode == 2'h3) && phy_tx_en[0] && !phy_rx_en[0]);
    c_hw_release: cover property ((state == pmm_pkg::ST_HW_PD) ##1 internal_reset);

endmodule

// ==== pmm_pkg.sv ====
// power mode manager package: register map, field positions, reset values,
// modes, fsm states and timing constants.
// assumes a 250 MHz sys_clk and an 8-bit register port with byte addresses.
package pmm_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_CTRL_OFS = 8'h0e;   // power_mode_control
    localparam logic [7:0] SLEEP_OFS = 8'h0f;       // sleep_timeout_setting
    localparam logic [7:0] PORT_CTRL_OFS = 8'h1d;   // port1_phy_control
    localparam logic [7:0] PORT_STRIDE = 8'h10;     // next port's copy of that register
    localparam int NUM_PORTS = 5;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int MODE_POS = 3;                    // mode field is bits [4:3]
    localparam int PORT_PD_BIT = 3;                 // per-port power-down bit
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [7:0] SLEEP_RST = 8'h10;
    localparam logic [7:0] PORT_CTRL_RST = 8'h00;

    // ------------------------------------------------------------
    // power modes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_ENERGY = 2'h1;
    localparam logic [1:0] MODE_SOFT_PD = 2'h2;
    localparam logic [1:0] MODE_PSAVE = 2'h3;

    typedef enum logic [2:0] {
        ST_HW_PD = 3'b000,
        ST_RUN = 3'b001,
        ST_ED_AWAKE = 3'b010,
        ST_ED_SLEEP = 3'b011,
        ST_SOFT_PD = 3'b100
    } pmm_state_t;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int CLK_HZ = 250000000;
    localparam int ED_PULSE_WIDTH_NS = 120;
    localparam int ED_PULSE_WIDTH_CYC = (ED_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ED_PULSE_PERIOD_S = 1;
    localparam int ED_PULSE_PERIOD_CYC = ED_PULSE_PERIOD_S * CLK_HZ;
    localparam int SLEEP_UNIT_US = 1000;
    localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_US * (CLK_HZ / 1000000);

endpackage

// ==== pmm_pulse_gen.sv ====
// periodic tick and pulse generator.
// assumes run comes from logic on sys_clk; counter restarts whenever run drops.
`timescale 1ns/1ps
module pmm_pulse_gen #(
    parameter int unsigned PERIOD = 2,
    parameter int unsigned WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic run,
    output logic tick,
    output logic pulse
);

    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic next_tick;
    logic next_pulse;

    // ------------------------------------------------------------
    // counter: pulse is high for the first WIDTH cycles of each period
    // ------------------------------------------------------------
    always_comb begin
        next_cnt = 32'h0000_0000;
        next_tick = 1'b0;
        next_pulse = 1'b0;
        if (run) begin
            next_tick = (cnt == PERIOD - 1);
            next_cnt = next_tick ? 32'h0000_0000 : cnt + 32'h0000_0001;
            next_pulse = (cnt < WIDTH);
        end
    end

    // registered outputs only
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 32'h0000_0000;
            tick <= 1'b0;
            pulse <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick <= next_tick;
            pulse <= next_pulse;
        end
    end

endmodule

// ==== pmm_host_model.sv ====
// host processor model: issues single register accesses on the block's
// strobe port and hands back the answer.
// assumes reg_ack and reg_rdata are registered and come one edge after the strobe.
`timescale 1ns/1ps
module pmm_host_model (
    input wire logic sys_clk,
    input wire logic reg_ack,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata
);
    // ------------------------------------------------------------
    // access task
    // ------------------------------------------------------------
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // one-cycle strobe; released bus shows inverted values so stale data cannot pass
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                          output logic ack, output logic [7:0] q);
        @(posedge sys_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = wr;      // host picks the mode by a write
        reg_rd = !wr;     // any access wakes a soft-off chip
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        ack = reg_ack;
        q = reg_rdata;
    endtask
endmodule

// ==== pmm_power_manager_tb.sv ====
// self-checking bench for the power mode manager: register access, port power
// down, saving, soft power down, energy detect and the power-down pin.
// assumes short counts via parameters; host model drives the register port.
`timescale 1ns/1ps
module pmm_power_manager_tb;
    localparam int PER = 200;
    localparam int UNIT = 20;
    logic sys_clk, rstn, pin_n;
    logic [4:0] energy, aneg, miim_pd;
    wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
    wire logic reg_wr, reg_rd, reg_ack, pll_clk_en, mac_en, host_if_en;
    wire logic energy_pulse, low_power_state, internal_reset;
    wire logic [4:0] phy_tx_en, phy_rx_en;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n, m;
    logic ack;
    logic [7:0] q;

    // ------------------------------------------------------------
    // design, host and clock
    // ------------------------------------------------------------
    pmm_power_manager #(.ED_PULSE_PERIOD_CYC(PER), .SLEEP_UNIT_CYC(UNIT)) dut (
        .sys_clk(sys_clk), .rstn(rstn), .chip_powerdown_n_pin(pin_n),
        .cable_energy_pin(energy), .autoneg_en(aneg), .miim_pd(miim_pd),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack), .pll_clk_en(pll_clk_en),
        .mac_en(mac_en), .host_if_en(host_if_en), .phy_tx_en(phy_tx_en),
        .phy_rx_en(phy_rx_en), .energy_pulse(energy_pulse),
        .low_power_state(low_power_state), .internal_reset(internal_reset));
    pmm_host_model u_host (
        .sys_clk(sys_clk), .reg_ack(reg_ack), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // the whole run needs about 300 cycles; far beyond that means a hang
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_read(input logic [7:0] a, input logic [7:0] exp);
        u_host.access(1'b0, a, 8'h00, ack, q);
        chk({7'h0, ack}, 8'h01);
        chk(q, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.access(1'b1, a, d, ack, q);
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    function automatic logic [7:0] en3();
        return {pll_clk_en, mac_en, host_if_en, 5'h00};
    endfunction

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        pin_n = 1'b1;
        energy = 5'h1f;
        aneg = 5'h00;
        miim_pd = 5'h00;
        cyc(3);
        rstn = 1'b1;
        cyc(3);
        chk(en3(), 8'he0);
        chk({3'h0, phy_tx_en & phy_rx_en}, 8'h1f);
        chk_read(8'h0e, 8'h00);
        chk_read(8'h0f, 8'h10);
        chk_read(8'h1d, 8'h00);
        chk_read(8'h5d, 8'h00);
        chk_read(8'h00, 8'h00);
        $display("test reset done");

        wr(8'h0f, 8'h03);
        chk_read(8'h0f, 8'h03);
        wr(8'h2d, 8'h08);
        wr(8'h1d, 8'h08);
        cyc(3);
        chk({3'h0, phy_tx_en | phy_rx_en}, 8'h1c);
        chk_read(8'h2d, 8'h08);
        wr(8'h2d, 8'h00);
        wr(8'h1d, 8'h00);
        miim_pd = 5'h04;
        cyc(3);
        chk({3'h0, phy_tx_en}, 8'h1b);
        miim_pd = 5'h00;
        $display("test port power down done");

        // port 2 without auto-negotiation keeps its receiver on
        aneg = 5'h1d;
        energy = 5'h00;
        wr(8'h0e, 8'h18);
        cyc(6);
        chk({3'h0, phy_rx_en}, 8'h02);
        chk({3'h0, phy_tx_en}, 8'h1f);
        chk(en3(), 8'he0);
        chk_read(8'h0f, 8'h03);
        energy = 5'h1f;
        cyc(6);
        chk({3'h0, phy_rx_en}, 8'h1f);
        wr(8'h0e, 8'h00);
        chk_read(8'h0e, 8'h00);
        $display("test power saving done");

        wr(8'h0f, 8'h05);
        wr(8'h0e, 8'h10);
        cyc(4);
        chk(en3() | {3'h0, phy_tx_en | phy_rx_en}, 8'h00);
        u_host.access(1'b0, 8'h0f, 8'h00, ack, q);
        chk({7'h0, ack}, 8'h00);
        chk({7'h0, internal_reset}, 8'h01);
        cyc(2);
        chk(en3(), 8'he0);
        chk_read(8'h0f, 8'h10);
        $display("test soft power down done");

        wr(8'h0f, 8'h02);
        energy = 5'h00;
        wr(8'h0e, 8'h08);
        for (n = 0; n < 50 && energy_pulse !== 1'b1; n++) cyc(1);
        for (n = 0; n < 100 && energy_pulse === 1'b1; n++) cyc(1);
        chk(8'(n), 8'(pmm_pkg::ED_PULSE_WIDTH_CYC));
        chk({7'h0, low_power_state}, 8'h00);
        for (m = 0; m < 400 && energy_pulse !== 1'b1; m++) cyc(1);
        chk(8'(n + m), 8'(PER));
        chk({7'h0, low_power_state}, 8'h01);
        chk(en3(), 8'h00);
        u_host.access(1'b0, 8'h0f, 8'h00, ack, q);
        chk({7'h0, ack}, 8'h00);
        energy = 5'h08;
        for (n = 0; n < 20 && low_power_state !== 1'b0; n++) cyc(1);
        cyc(2);
        chk(en3(), 8'he0);
        wr(8'h0e, 8'h00);
        chk_read(8'h0e, 8'h08);
        $display("test energy detect done");

        pin_n = 1'b0;
        cyc(5);
        chk(en3(), 8'h00);
        u_host.access(1'b0, 8'h0e, 8'h00, ack, q);
        chk({7'h0, ack}, 8'h00);
        pin_n = 1'b1;
        for (n = 0; n < 10 && internal_reset !== 1'b1; n++) cyc(1);
        chk({7'h0, internal_reset}, 8'h01);
        cyc(2);
        chk_read(8'h0e, 8'h00);
        chk_read(8'h0f, 8'h10);
        $display("test power-down pin done");
        results();
    end
endmodule
